// ### spb_defs.svh
/*
 * Offsets, field positions and reset values of the buffered serial port.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SPB_DEFS_SVH
`define SPB_DEFS_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define SPB_A_CTRL 8'h00
`define SPB_A_FMT_HI 4'h1
`define SPB_A_TX 8'h20
`define SPB_A_RX 8'h24
`define SPB_A_STAT 8'h28
// ************************************************************
// Global control fields
// ************************************************************
`define SPB_C_ROLE 0
`define SPB_C_CLKSRC 1
`define SPB_C_TXREQ 2
`define SPB_C_RXREQ 3
`define SPB_C_RXINT 4
`define SPB_C_OVINT 5
`define SPB_C_RDYEN 6
`define SPB_CTRL_RST 32'h0000_0000
// ************************************************************
// Word format fields
// ************************************************************
`define SPB_F_LEN 4:0
`define SPB_F_ORD 8
`define SPB_F_POL 9
`define SPB_F_PHA 10
`define SPB_F_DIV 23:16
`define SPB_FMT_RST 32'h0003_0010
// ************************************************************
// Transmit and receive word fields
// ************************************************************
`define SPB_T_DATA 15:0
`define SPB_T_FSEL 17:16
`define SPB_T_SEL 25:24
`define SPB_R_EMPTY 31
`define SPB_R_OVR 30
`endif

// ### spb_pkg.sv
/*
 * Types of the buffered serial port.
 * Assumes nothing of its surroundings.
 */
package spb_pkg;
    typedef enum logic [0:0] {
        SPB_IDLE = 1'b0,
        SPB_RUN = 1'b1
    } spb_state_t;
endpackage : spb_pkg

// ### spb_top.sv
/*
 * Buffered serial port, controller or target, with four word formats.
 * Assumes one clock, a synchronous reset and a strobe register port.
 */
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "spb_defs.svh"
module spb_top import spb_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic TX_REQ,
    output logic RX_REQ,
    output logic RX_INT,
    output logic OVR_INT,
    input wire logic SCLK_I,
    output logic SCLK_O,
    output logic SCLK_OE,
    input wire logic CO_I,
    output logic CO_O,
    output logic CO_OE,
    input wire logic CI_I,
    output logic CI_O,
    output logic CI_OE,
    input wire logic READY_N_I,
    output logic READY_N_O,
    output logic READY_N_OE,
    input wire logic SEL0_N_I,
    output logic SEL0_N_O,
    output logic SEL0_N_OE,
    input wire logic SEL1_N_I,
    output logic SEL1_N_O,
    output logic SEL1_N_OE
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic sclk_d_r;
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            meta_r <= 6'h3f;
            sync_r <= 6'h3f;
            sclk_d_r <= 1'b0;
        end else begin
            meta_r <= {SEL1_N_I, SEL0_N_I, READY_N_I, CI_I, CO_I, SCLK_I};
            sync_r <= meta_r;
            sclk_d_r <= sync_r[0];
        end
    end

    // ************************************************************
    // Registers and decode
    // ************************************************************
    logic [31:0] ctrl_r;
    logic [31:0] fmt_r [4];
    logic [19:0] hold_r;
    logic [3:0] act_r;
    logic [15:0] sh_r;
    logic [15:0] rbuf_r;
    logic [15:0] rhold_r;
    logic sfull_r, hfull_r, rfull_r, rhfull_r, ovr_r;
    spb_state_t st_r;
    logic ctrl_m, wr_tx, rd_rx;
    logic [31:0] cur;
    logic [4:0] len;
    logic ord, pol, pha;
    logic [7:0] div;

    assign ctrl_m = ctrl_r[`SPB_C_ROLE] & ctrl_r[`SPB_C_CLKSRC];
    assign wr_tx = WR && ADDR == `SPB_A_TX;
    assign rd_rx = RD && ADDR == `SPB_A_RX;
    assign cur = fmt_r[act_r[1:0]];
    assign len = cur[`SPB_F_LEN];
    assign ord = cur[`SPB_F_ORD];
    assign pol = cur[`SPB_F_POL];
    assign pha = cur[`SPB_F_PHA];
    assign div = cur[`SPB_F_DIV];

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl_r <= `SPB_CTRL_RST;
            for (int i = 0; i < 4; i++) begin
                fmt_r[i] <= `SPB_FMT_RST;
            end
        end else if (WR) begin
            if (ADDR == `SPB_A_CTRL) begin
                ctrl_r <= WDATA;
            end
            if (ADDR[7:4] == `SPB_A_FMT_HI && ADDR[1:0] == 2'h0) begin
                fmt_r[ADDR[3:2]] <= WDATA;
            end
        end
    end

    // ************************************************************
    // Bit timing
    // ************************************************************
    logic [7:0] cnt_r;
    logic [4:0] nbit_r;
    logic sclk_r, out_r;
    logic sel_act, din, lead, trail, smp, shout, done, start, top;
    logic lead_c, trail_c, lead_t, trail_t;
    logic [4:0] nbit_nxt;
    logic [15:0] shf, rxw;

    assign sel_act = ~sync_r[4] | ~sync_r[5];
    assign din = ctrl_m ? sync_r[2] : sync_r[1];
    // Leading half is div/2+1 clocks (div/2 rounded down), whole bit is div+1 clocks
    assign lead_c = cnt_r == {1'b0, div[7:1]};
    assign trail_c = cnt_r == div;
    assign lead_t = sync_r[0] != sclk_d_r && sync_r[0] != pol;
    assign trail_t = sync_r[0] != sclk_d_r && sync_r[0] == pol;
    assign lead = st_r == SPB_RUN && (ctrl_m ? lead_c : lead_t);
    assign trail = st_r == SPB_RUN && (ctrl_m ? trail_c : trail_t);
    assign smp = pha ? lead : trail;
    assign shout = pha ? trail : lead;
    assign nbit_nxt = nbit_r + {4'h0, smp};
    assign done = trail && nbit_nxt == len;
    assign top = ord ? sh_r[0] : sh_r[4'(len - 5'h1)];
    // LSB-first input enters at the word's top bit to stay right-justified
    always_comb begin
        shf = {sh_r[14:0], din};
        if (ord) begin
            shf = sh_r >> 1;
            shf[4'(len - 5'h1)] = din;
        end
    end
    assign rxw = smp ? shf : sh_r;
    // Ready is checked only before a word; a target cannot stall mid-word
    assign start = ctrl_m ? sfull_r && (!ctrl_r[`SPB_C_RDYEN] || !sync_r[3])
                          : sel_act;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_r <= SPB_IDLE;
        end else begin
            case (st_r)
                SPB_IDLE: begin
                    if (start) begin
                        st_r <= SPB_RUN;
                    end
                end
                SPB_RUN: begin
                    if (done || (!ctrl_m && !sel_act)) begin
                        st_r <= SPB_IDLE;
                    end
                end
                default: st_r <= SPB_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET || st_r == SPB_IDLE) begin
            cnt_r <= 8'h00;
            nbit_r <= 5'h00;
        end else begin
            cnt_r <= trail_c ? 8'h00 : cnt_r + 8'h01;
            nbit_r <= nbit_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sclk_r <= 1'b0;
        end else if (st_r == SPB_IDLE) begin
            sclk_r <= pol;
        end else if (lead_c || trail_c) begin
            sclk_r <= ~sclk_r;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            out_r <= 1'b0;
        end else if ((st_r == SPB_IDLE && start && pha) || (shout && !done)) begin
            out_r <= top;
        end
    end

    // ************************************************************
    // Transmit path
    // ************************************************************
    logic to_hold, from_hold, tx_ld;
    assign to_hold = wr_tx && (sfull_r || hfull_r) && !(done && !hfull_r);
    assign from_hold = done && hfull_r;
    assign tx_ld = (wr_tx && !to_hold) || from_hold;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sfull_r <= 1'b0;
            hfull_r <= 1'b0;
            hold_r <= 20'h00000;
            act_r <= 4'h0;
            TX_REQ <= 1'b0;
        end else begin
            if (tx_ld) begin
                sfull_r <= 1'b1;
                act_r <= from_hold ? hold_r[19:16]
                                   : {WDATA[`SPB_T_SEL], WDATA[`SPB_T_FSEL]};
            end else if (done) begin
                sfull_r <= 1'b0;
            end
            if (to_hold) begin
                hfull_r <= 1'b1;
                hold_r <= {WDATA[`SPB_T_SEL], WDATA[`SPB_T_FSEL], WDATA[`SPB_T_DATA]};
            end else if (from_hold) begin
                hfull_r <= 1'b0;
            end
            TX_REQ <= tx_ld && ctrl_r[`SPB_C_TXREQ];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sh_r <= 16'h0000;
        end else if (tx_ld) begin
            sh_r <= from_hold ? hold_r[15:0] : WDATA[`SPB_T_DATA];
        end else if (smp) begin
            sh_r <= shf;
        end
    end

    // ************************************************************
    // Receive path
    // ************************************************************
    logic rfull_nxt, rhfull_nxt, ovr_nxt, rx_req_nxt;
    logic [15:0] rbuf_nxt, rhold_nxt;
    always_comb begin
        rfull_nxt = rfull_r;
        rhfull_nxt = rhfull_r;
        rbuf_nxt = rbuf_r;
        rhold_nxt = rhold_r;
        ovr_nxt = ovr_r && !rd_rx;
        rx_req_nxt = 1'b0;
        if (rd_rx) begin
            if (rhfull_r) begin
                rbuf_nxt = rhold_r;
                rhfull_nxt = 1'b0;
            end else begin
                rfull_nxt = 1'b0;
            end
        end
        if (done) begin
            if (!rfull_nxt) begin
                rbuf_nxt = rxw;
                rfull_nxt = 1'b1;
                rx_req_nxt = 1'b1;
            end else if (!rhfull_nxt) begin
                rhold_nxt = rxw;
                rhfull_nxt = 1'b1;
                rx_req_nxt = 1'b1;
            end else begin
                rhold_nxt = rxw;
                ovr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rfull_r <= 1'b0;
            rhfull_r <= 1'b0;
            ovr_r <= 1'b0;
            rbuf_r <= 16'h0000;
            rhold_r <= 16'h0000;
            RX_REQ <= 1'b0;
        end else begin
            rfull_r <= rfull_nxt;
            rhfull_r <= rhfull_nxt;
            ovr_r <= ovr_nxt;
            rbuf_r <= rbuf_nxt;
            rhold_r <= rhold_nxt;
            RX_REQ <= rx_req_nxt && ctrl_r[`SPB_C_RXREQ];
        end
    end

    assign RX_INT = rfull_r && ctrl_r[`SPB_C_RXINT];
    assign OVR_INT = ovr_r && ctrl_r[`SPB_C_OVINT];

    // ************************************************************
    // Read data and pins
    // ************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (RESET || !RD) begin
            RDATA <= 32'h0000_0000;
        end else if (ADDR == `SPB_A_CTRL) begin
            RDATA <= ctrl_r;
        end else if (ADDR[7:4] == `SPB_A_FMT_HI && ADDR[1:0] == 2'h0) begin
            RDATA <= fmt_r[ADDR[3:2]];
        end else if (ADDR == `SPB_A_RX) begin
            RDATA <= {~rfull_r, ovr_r, 14'h0000, rbuf_r};
        end else if (ADDR == `SPB_A_STAT) begin
            RDATA <= {28'h0000000, rhfull_r, sfull_r, st_r == SPB_RUN, hfull_r};
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    logic [1:0] seln_r;
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            seln_r <= 2'h3;
        end else begin
            seln_r <= ~(act_r[3:2] & {2{st_r == SPB_RUN || (start && ctrl_m)}});
        end
    end

    assign SCLK_O = sclk_r;
    assign SCLK_OE = ctrl_m;
    assign CO_O = out_r;
    assign CO_OE = ctrl_m;
    assign CI_O = out_r;
    assign CI_OE = !ctrl_m && sel_act;
    assign READY_N_O = ~sfull_r;
    assign READY_N_OE = !ctrl_m;
    assign SEL0_N_O = seln_r[0];
    assign SEL1_N_O = seln_r[1];
    assign SEL0_N_OE = ctrl_m;
    assign SEL1_N_OE = ctrl_m;

    // ************************************************************
    // Checks
    // ************************************************************
    tx_direct_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        wr_tx && !sfull_r && !hfull_r |=> sfull_r && !hfull_r)
        else $error("direct load missed");
    tx_hold_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        wr_tx && sfull_r && !done |=> hfull_r)
        else $error("holding full not set");
    tx_refill_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        done && hfull_r && !wr_tx |=> sfull_r && !hfull_r)
        else $error("holding word not moved");
    rx_first_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        done && !rfull_r && !rd_rx |=> rfull_r && rbuf_r == $past(rxw))
        else $error("receive buffer not filled");
    rx_move_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        rd_rx && rhfull_r && !done |=> rfull_r && !rhfull_r)
        else $error("held word not moved");
    rx_overrun_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        done && rfull_r && rhfull_r && !rd_rx |=> ovr_r && rhfull_r)
        else $error("overrun not flagged");
    clk_idle_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        st_r == SPB_IDLE ##1 st_r == SPB_IDLE |-> sclk_r == $past(pol))
        else $error("idle clock level wrong");
    ready_wait_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ctrl_m && st_r == SPB_IDLE && ctrl_r[`SPB_C_RDYEN] && sync_r[3] |=> st_r == SPB_IDLE)
        else $error("clock started while target not ready");
endmodule : spb_top

// ### spb_peer.sv
/*
 * Serial target model facing the port in controller role.
 * Assumes it sees the port's clock, select zero and data lines on the system clock.
 */
`timescale 1ns/10ps
module spb_peer (
    input wire logic clk,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic pol,
    input wire logic stall,
    input wire logic [4:0] nbits,
    input wire logic [15:0] reply,
    output logic miso,
    output logic ready_n,
    output logic [15:0] got
);
    // ************************************************************
    // Frame engine, echoes the previous word after the first one
    // ************************************************************
    logic sclk_d = 1'b0;
    logic sel_d = 1'b1;
    logic first = 1'b1;
    logic [4:0] cnt = 5'h00;
    logic [15:0] sh = 16'h0000;
    logic [15:0] prev = 16'h0000;
    logic [15:0] s;
    initial miso = 1'b0;
    initial got = 16'h0000;
    assign ready_n = stall;
    always @(posedge clk) begin
        sclk_d <= sclk;
        sel_d <= sel_n;
        if (sel_n) begin
            // Released line never holds a steady level
            miso <= ~miso;
            cnt <= 5'h00;
        end else if (sel_d) begin
            // First bit stands from select on; the port's input synchroniser needs the slack
            s = first ? reply : prev << (5'h10 - nbits);
            miso <= s[15];
            sh <= s << 1;
        end else if (!(sclk ^ pol) && (sclk_d ^ pol)) begin
            got <= {got[14:0], mosi};
            cnt <= cnt + 5'h01;
            miso <= sh[15];
            sh <= sh << 1;
            if (cnt + 5'h01 == nbits) begin
                // Select may stay low into the next word: reload at once
                s = {got[14:0], mosi} << (5'h10 - nbits);
                miso <= s[15];
                sh <= s << 1;
                prev <= {got[14:0], mosi};
                first <= 1'b0;
                cnt <= 5'h00;
            end
        end
    end
endmodule : spb_peer

// ### spb_top_tb.sv
/*
 * Self-checking bench of the buffered serial port in controller role.
 * Assumes the design top and the target model spb_peer in the same folder.
 */
`timescale 1ns/10ps
module spb_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic tx_req, rx_req, rx_int, ovr_int, sclk_o, sclk_oe, co_o, co_oe;
    logic ci_i, ci_o, ci_oe, rdy_n, rdy_o, rdy_oe, s0_o, s0_oe, s1_o, s1_oe;
    logic pol = 1'b0;
    logic stall = 1'b0;
    logic [4:0] nbits = 5'h08;
    logic [15:0] got;
    logic txs;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n_req = 0;

    spb_top dut_u (.SYS_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .TX_REQ(tx_req), .RX_REQ(rx_req), .RX_INT(rx_int),
        .OVR_INT(ovr_int), .SCLK_I(1'b0), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe),
        .CO_I(1'b0), .CO_O(co_o), .CO_OE(co_oe), .CI_I(ci_i), .CI_O(ci_o), .CI_OE(ci_oe),
        .READY_N_I(rdy_n), .READY_N_O(rdy_o), .READY_N_OE(rdy_oe), .SEL0_N_I(1'b1),
        .SEL0_N_O(s0_o), .SEL0_N_OE(s0_oe), .SEL1_N_I(1'b1), .SEL1_N_O(s1_o),
        .SEL1_N_OE(s1_oe));
    spb_peer peer_u (.clk(clk), .sclk(sclk_o), .sel_n(s0_o), .mosi(co_o), .pol(pol),
        .stall(stall), .nbits(nbits), .reply(16'hc300), .miso(ci_i), .ready_n(rdy_n),
        .got(got));

    // ************************************************************
    // Clock, timeout and bus tasks
    // ************************************************************
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : op
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, 8'h00, 32'h0);
    endtask : wr32
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
        input string nm);
        logic [31:0] v;
        op(1'b0, 1'b1, a, 32'h0);
        #1 v = rdata;
        op(1'b0, 1'b0, 8'h00, 32'h0);
        chk(nm, e & m, v & m);
    endtask : rdchk
    // Cycles between two clock rises; zero when no rise is seen
    task automatic period(input int e, input int lim, input string nm);
        int t, a1, a2;
        logic p;
        a1 = -1;
        a2 = -1;
        p = sclk_o;
        for (t = 0; t < lim && a2 < 0; t++) begin
            @(posedge clk);
            #1;
            if (sclk_o === 1'b1 && p === 1'b0) begin
                if (a1 < 0) begin
                    a1 = t;
                end else begin
                    a2 = t;
                end
            end
            p = sclk_o;
        end
        chk(nm, 32'(e), 32'(a2 - a1));
    endtask : period
    task automatic wait_rx(output logic tx_seen);
        int n;
        n = 0;
        #1;
        while (rx_req !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        tx_seen = tx_req;
        chk("rx req", 1, rx_req);
        // Target takes the last bit one cycle after the request
        @(posedge clk);
        #1;
    endtask : wait_rx

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(8'h24, 32'h8000_0000, 32'hc000_0000, "rx after reset");
        rdchk(8'h28, 32'h0, 32'hf, "status after reset");
        rdchk(8'h10, 32'h0003_0010, 32'hffff_ffff, "format reset");
        chk("clock oe target", 0, sclk_oe);
        chk("ready oe target", 1, rdy_oe);
        $display("test reset done");
        wr32(8'h00, 32'h0000_007f);
        wr32(8'h10, 32'h0003_0008);
        wr32(8'h14, 32'h0007_0110);
        wr32(8'h18, 32'h0003_0202);
        rdchk(8'h14, 32'h0007_0110, 32'hffff_ffff, "format one");
        chk("clock oe", 1, sclk_oe);
        chk("data oe", 2, {co_oe, ci_oe});
        chk("select and ready oe", 2, {s0_oe, rdy_oe});
        $display("test roles done");
        op(1'b1, 1'b0, 8'h20, 32'h0100_00a5);
        #1 chk("tx req on load", 1, tx_req);
        op(1'b1, 1'b0, 8'h20, 32'h0100_003c);
        op(1'b1, 1'b0, 8'h20, 32'h0100_005a);
        op(1'b0, 1'b0, 8'h00, 32'h0);
        rdchk(8'h28, 32'h1, 32'h1, "holding full");
        period(4, 200, "clock period");
        wait_rx(txs);
        chk("tx req on refill", 1, txs);
        chk("peer word", 32'ha5, {24'h0, got[7:0]});
        rdchk(8'h28, 32'h0, 32'h1, "holding drained");
        chk("rx int", 1, rx_int);
        wr32(8'h20, 32'h0100_0096);
        wait_rx(txs);
        rdchk(8'h28, 32'h8, 32'h8, "rx holding full");
        chk("rx int held", 1, rx_int);
        repeat (60) begin
            op(1'b0, 1'b0, 8'h00, 32'h0);
            #1 n_req += rx_req;
        end
        chk("rx req on overrun", 0, n_req);
        rdchk(8'h28, 32'h0, 32'h2, "idle after three");
        chk("overrun int", 1, ovr_int);
        rdchk(8'h24, 32'h4000_00c3, 32'hc000_00ff, "rx first word");
        rdchk(8'h24, 32'h0000_005a, 32'hc000_00ff, "rx overwritten");
        rdchk(8'h24, 32'h8000_0000, 32'hc000_0000, "rx empty again");
        $display("test buffers done");
        stall <= 1'b1;
        nbits <= 5'h10;
        repeat (3) op(1'b0, 1'b0, 8'h00, 32'h0);
        wr32(8'h20, 32'h0101_1234);
        period(0, 40, "stalled clock");
        stall <= 1'b0;
        period(8, 300, "format one period");
        wait_rx(txs);
        chk("lsb first word", 32'h2c48, {16'h0, got});
        $display("test format one done");
        pol <= 1'b1;
        nbits <= 5'h02;
        wr32(8'h20, 32'h0102_0002);
        wait_rx(txs);
        repeat (2) op(1'b0, 1'b0, 8'h00, 32'h0);
        chk("idle clock high", 1, sclk_o);
        chk("two bit word", 32'h2, {30'h0, got[1:0]});
        $display("test format two done");
        summarize();
    end
endmodule : spb_top_tb
